// ==== rtl/chgi2c_pkg.sv ====
// Shared constants and types of the charger two-wire slave.
package chgi2c_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus constants
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] DEV_ADDR = 7'h6A;
   localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
   localparam logic [4:0] REG_ADDR_ZERO = 5'h00;
   localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CONTROL = 3'h1;
   localparam logic [2:0] REG_VOLTAGE = 3'h2;
   localparam logic [2:0] REG_ID = 3'h3;
   localparam logic [2:0] REG_CURRENT = 3'h4;
   localparam logic [2:0] REG_LAST = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and status field positions
   localparam logic [7:0] CONTROL_RESET = 8'h30;
   localparam logic [7:0] VOLTAGE_RESET = 8'h0A;
   localparam logic [7:0] CURRENT_RESET = 8'h01;
   localparam logic STAT_EN_RESET = 1'h1;
   localparam int TMR_BIT = 7;
   localparam int STAT_EN_BIT = 6;

   ////////////////////////////////////////////////////////////////////////
   // Fault codes, charge operation
   localparam logic [2:0] FLT_NORMAL = 3'h0;
   localparam logic [2:0] FLT_IN_OVP = 3'h1;
   localparam logic [2:0] FLT_SLEEP = 3'h2;
   localparam logic [2:0] FLT_BAD_SUPPLY = 3'h3;
   localparam logic [2:0] FLT_OUT_OVP = 3'h4;
   localparam logic [2:0] FLT_THERMAL = 3'h5;
   localparam logic [2:0] FLT_TIMER = 3'h6;
   localparam logic [2:0] FLT_NO_BATT = 3'h7;
   // Fault codes, step-up operation
   localparam logic [2:0] FLT_UP_BUS_OVP = 3'h1;
   localparam logic [2:0] FLT_UP_OVERLOAD = 3'h2;
   localparam logic [2:0] FLT_UP_BATT_LOW = 3'h3;
   localparam logic [2:0] FLT_UP_BATT_OVP = 3'h4;
   localparam logic [2:0] FLT_UP_UNUSED = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Serial state machine
   typedef enum logic [3:0] {
      S_IDLE,
      S_ADDR,
      S_AACK,
      S_REG,
      S_PACK,
      S_WDATA,
      S_WACK,
      S_RDATA,
      S_MACK,
      S_SKIP
   } chgi2c_state_t;

endpackage

// ==== rtl/chgi2c_bus_cond.sv ====
// Pin synchronisers and bus condition detector of the charger slave.
`timescale 1ns/10ps
module chgi2c_bus_cond
   import chgi2c_pkg::*;
#(
   parameter int NPINS = 3
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Raw pins: bit 0 clock line, bit 1 data line, others plain levels
   input wire logic [NPINS-1:0] pin_raw,
   // Synchronised levels and events
   output logic [NPINS-1:0] pin_lvl,
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det
);

   logic [NPINS-1:0] meta_reg;
   logic [NPINS-1:0] prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // Two synchroniser flip-flops per pin plus an edge-history stage; the first stage feeds no other logic
   genvar i;
   generate
      for (i = 0; i < NPINS; i++)
      begin : g_sync
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               meta_reg[i] <= 1'h1;
               pin_lvl[i] <= 1'h1;
               prev_reg[i] <= 1'h1;
            end
            else
            begin
               meta_reg[i] <= pin_raw[i];
               pin_lvl[i] <= meta_reg[i];
               prev_reg[i] <= pin_lvl[i];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Data edges only count as conditions while the clock line stays high
   assign scl_rise = pin_lvl[0] && !prev_reg[0];
   assign scl_fall = !pin_lvl[0] && prev_reg[0];
   assign start_det = pin_lvl[0] && prev_reg[0] && prev_reg[1] && !pin_lvl[1];
   assign stop_det = pin_lvl[0] && prev_reg[0] && !prev_reg[1] && pin_lvl[1];

endmodule

// ==== rtl/chgi2c_slave.sv ====
// Two-wire slave front end and status/control register of the charger.
//
// What this block does
// - Falling data while clock high starts transfer.
// - Acknowledge own address, data low ninth clock.
// - Receiver of each data byte acknowledges it.
// - Eight data bits plus acknowledge, repeated.
// - Rising data while clock high stops, releases.
// - Unlisted register addresses read back all ones.
// - Master code never acknowledged, enters high speed.
// - Repeated start, then normal bytes at speed.
// - Stop leaves high-speed operation.
// - Write is start, address, pointer, data.
// - Write commits at falling edge of acknowledge.
// - Further pointer-data pairs need no new start.
// - Pointer upper five bits zero, five registers.
// - Status bit 7 restarts timer, reads host pin.
// - Status bit 6 enables indicator, resets one.
// - Status bit 3 shows step-up operation.
// - Fault field codes in charge operation.
// - Fault field codes in step-up operation.
// - Fixed seven-bit address only.
`timescale 1ns/10ps
module chgi2c_slave
   import chgi2c_pkg::*;
#(
   // Identification byte; the value is arbitrary
   parameter logic [7:0] ID_VALUE = 8'h5A
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial bus, data line is open drain
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic sda_out,
   output logic sda_oe,
   // Live device state
   input wire logic host_detect_pin,
   input wire logic charge_state_hi,
   input wire logic charge_state_lo,
   input wire logic step_up_active,
   input wire logic [2:0] fault_code,
   // Control outputs
   output logic timer_restart,
   output logic stat_enable,
   output logic fault_present,
   output logic hs_mode,
   output logic [7:0] cfg_control,
   output logic [7:0] cfg_voltage,
   output logic [7:0] cfg_current
);

   logic [2:0] pin_lvl;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_lvl;
   logic host_lvl;
   chgi2c_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_shift_reg;
   logic [7:0] tx_shift_reg;
   logic [2:0] reg_ptr_reg;
   logic ptr_ok_reg;
   logic read_dir_reg;
   logic ack_seen_reg;
   logic sda_drive_reg;
   logic hs_mode_reg;
   logic stat_en_reg;
   logic timer_restart_reg;
   logic fault_present_reg;
   logic [7:0] control_reg;
   logic [7:0] voltage_reg;
   logic [7:0] current_reg;
   logic [7:0] rd_data;
   logic in_byte;
   logic byte_end;
   logic addr_hit;
   logic hs_code;
   logic wr_en;
   logic tx_load;

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling
   chgi2c_bus_cond #(
      .NPINS(3)
   ) u_cond (
      .clk(clk),
      .reset_n(reset_n),
      .pin_raw({host_detect_pin, sda_pin, scl_pin}),
      .pin_lvl(pin_lvl),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   assign sda_lvl = pin_lvl[1];
   assign host_lvl = pin_lvl[2];

   ////////////////////////////////////////////////////////////////////////
   // Byte framing
   assign in_byte = state_reg == S_ADDR || state_reg == S_REG ||
      state_reg == S_WDATA || state_reg == S_RDATA;
   assign byte_end = scl_fall && in_byte && bit_cnt_reg == BITS_PER_BYTE;
   assign addr_hit = rx_shift_reg[7:1] == DEV_ADDR;
   assign hs_code = rx_shift_reg[7:3] == HS_CODE_PREFIX;
   assign wr_en = scl_fall && state_reg == S_WACK;
   assign tx_load = scl_fall && ((state_reg == S_AACK && read_dir_reg) ||
      (state_reg == S_MACK && ack_seen_reg));

   // Bit count runs 0..8 inside a byte and rests at 0 in acknowledge slots
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         bit_cnt_reg <= 4'h0;
      else if (start_det || stop_det || byte_end)
         bit_cnt_reg <= 4'h0;
      else if (scl_rise && in_byte)
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rx_shift_reg <= 8'h00;
      else if (scl_rise && in_byte && state_reg != S_RDATA)
         rx_shift_reg <= {rx_shift_reg[6:0], sda_lvl};
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial state machine; start and stop win from any state
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= S_IDLE;
      else if (start_det)
         state_reg <= S_ADDR;
      else if (stop_det)
         state_reg <= S_IDLE;
      else
      begin
         unique case (state_reg)
            S_IDLE, S_SKIP:
               state_reg <= state_reg;
            S_ADDR:
               if (byte_end)
                  state_reg <= addr_hit ? S_AACK : S_SKIP;
            S_AACK:
               if (scl_fall)
                  state_reg <= read_dir_reg ? S_RDATA : S_REG;
            S_REG:
               if (byte_end)
                  state_reg <= S_PACK;
            S_PACK:
               if (scl_fall)
                  state_reg <= S_WDATA;
            S_WDATA:
               if (byte_end)
                  state_reg <= S_WACK;
            S_WACK:
               if (scl_fall)
                  state_reg <= S_REG;
            S_RDATA:
               if (byte_end)
                  state_reg <= S_MACK;
            S_MACK:
               if (scl_fall)
                  state_reg <= ack_seen_reg ? S_RDATA : S_SKIP;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         read_dir_reg <= 1'h0;
      else if (state_reg == S_ADDR && byte_end)
         read_dir_reg <= rx_shift_reg[0];
   end

   // Master acknowledge is sampled while the clock is high
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ack_seen_reg <= 1'h0;
      else if (state_reg == S_MACK && scl_rise)
         ack_seen_reg <= !sda_lvl;
   end

   // The master code never matches the device address, so it goes unanswered
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hs_mode_reg <= 1'h0;
      else if (stop_det)
         hs_mode_reg <= 1'h0;
      else if (state_reg == S_ADDR && byte_end && hs_code)
         hs_mode_reg <= 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data line drive; changes after a clock fall has been seen, or clears at a start or stop
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         sda_drive_reg <= 1'h0;
      else if (start_det || stop_det)
         sda_drive_reg <= 1'h0;
      else if (tx_load)
         sda_drive_reg <= !rd_data[7];
      else if (byte_end)
         sda_drive_reg <= state_reg == S_ADDR ? addr_hit :
            state_reg != S_RDATA;
      else if (scl_fall && state_reg == S_RDATA)
         sda_drive_reg <= !tx_shift_reg[6];
      else if (scl_fall && state_reg != S_IDLE && state_reg != S_SKIP)
         sda_drive_reg <= 1'h0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         tx_shift_reg <= 8'h00;
      else if (tx_load)
         tx_shift_reg <= rd_data;
      else if (scl_fall && state_reg == S_RDATA && !byte_end)
         tx_shift_reg <= {tx_shift_reg[6:0], 1'h0};
   end

   assign sda_out = 1'h0;
   assign sda_oe = sda_drive_reg;

   ////////////////////////////////////////////////////////////////////////
   // Register pointer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_ptr_reg <= REG_STATUS;
         ptr_ok_reg <= 1'h1;
      end
      else if (state_reg == S_REG && byte_end)
      begin
         reg_ptr_reg <= rx_shift_reg[2:0];
         ptr_ok_reg <= rx_shift_reg[7:3] == REG_ADDR_ZERO &&
            rx_shift_reg[2:0] <= REG_LAST;
      end
   end

   // Read-only status fields are never stored, so writes cannot touch them
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         stat_en_reg <= STAT_EN_RESET;
      else if (wr_en && ptr_ok_reg && reg_ptr_reg == REG_STATUS)
         stat_en_reg <= rx_shift_reg[STAT_EN_BIT];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         timer_restart_reg <= 1'h0;
      else
         timer_restart_reg <= wr_en && ptr_ok_reg &&
            reg_ptr_reg == REG_STATUS && rx_shift_reg[TMR_BIT];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         control_reg <= CONTROL_RESET;
         voltage_reg <= VOLTAGE_RESET;
         current_reg <= CURRENT_RESET;
      end
      else if (wr_en && ptr_ok_reg)
      begin
         if (reg_ptr_reg == REG_CONTROL)
            control_reg <= rx_shift_reg;
         if (reg_ptr_reg == REG_VOLTAGE)
            voltage_reg <= rx_shift_reg;
         if (reg_ptr_reg == REG_CURRENT)
            current_reg <= rx_shift_reg;
      end
   end

   // Read mux; unlisted pointers fall through to all ones
   always_comb
   begin
      rd_data = UNMAPPED_BYTE;
      if (ptr_ok_reg)
      begin
         unique case (reg_ptr_reg)
            REG_STATUS:
               rd_data = {host_lvl, stat_en_reg, charge_state_hi,
                  charge_state_lo, step_up_active, fault_code};
            REG_CONTROL:
               rd_data = control_reg;
            REG_VOLTAGE:
               rd_data = voltage_reg;
            REG_ID:
               rd_data = ID_VALUE;
            REG_CURRENT:
               rd_data = current_reg;
            default:
               rd_data = UNMAPPED_BYTE;
         endcase
      end
   end

   // In step-up operation the top code means nothing and is not a fault
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         fault_present_reg <= 1'h0;
      else
         fault_present_reg <= fault_code != FLT_NORMAL &&
            !(step_up_active && fault_code == FLT_UP_UNUSED);
   end

   assign timer_restart = timer_restart_reg;
   assign stat_enable = stat_en_reg;
   assign fault_present = fault_present_reg;
   assign hs_mode = hs_mode_reg;
   assign cfg_control = control_reg;
   assign cfg_voltage = voltage_reg;
   assign cfg_current = current_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence addr_byte_done;
      state_reg == S_ADDR && byte_end;
   endsequence

   sequence ack_slot_open;
      sda_oe && (state_reg == S_AACK || state_reg == S_PACK ||
         state_reg == S_WACK);
   endsequence

   a_addr_ack_match: assert property (
      addr_byte_done and addr_hit |=> ack_slot_open)
      else $error("matching address not acknowledged");

   a_addr_no_ack: assert property (
      addr_byte_done and !addr_hit |=> !sda_oe && state_reg == S_SKIP)
      else $error("foreign address acknowledged");

   a_hs_code_enter: assert property (
      addr_byte_done and hs_code |=> hs_mode_reg && !sda_oe)
      else $error("master code not handled");

   a_stop_release: assert property (
      stop_det |=> state_reg == S_IDLE && !sda_oe && !hs_mode_reg)
      else $error("stop did not release bus");

   a_start_addr: assert property (
      start_det |=> state_reg == S_ADDR && bit_cnt_reg == 4'h0)
      else $error("start not taken");

   a_write_commit: assert property (
      wr_en && ptr_ok_reg && reg_ptr_reg == REG_CONTROL
      |=> cfg_control == $past(rx_shift_reg) && state_reg == S_REG)
      else $error("write not committed at acknowledge");

   a_timer_pulse: assert property (
      timer_restart |-> $past(wr_en) ##1 !timer_restart)
      else $error("timer restart not a single pulse");

   a_unmapped_ones: assert property (
      tx_load && !ptr_ok_reg |=> tx_shift_reg == UNMAPPED_BYTE)
      else $error("unlisted register not all ones");

   a_status_live: assert property (
      tx_load && ptr_ok_reg && reg_ptr_reg == REG_STATUS
      |=> tx_shift_reg[5:0] == $past({charge_state_hi, charge_state_lo,
         step_up_active, fault_code}) &&
         tx_shift_reg[7] == $past(host_lvl))
      else $error("status read not live");

endmodule

// ==== sim/chgi2c_master_model.sv ====
// Behavioural two-wire bus master that drives the charger slave.
`timescale 1ns/10ps
module chgi2c_master_model
(
   // Bus wires, data is open drain with a pull-up outside
   output logic scl,
   output logic sda_pull,
   input wire logic sda_line
);

   // Extra low time, lets the bench run the link slowly
   int slow_ns = 0;

   initial
   begin
      scl = 1'h1; // Clock stands high outside frames
      sda_pull = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data changes only in the low phase
   task automatic put_bit(input logic b);
      #(50 + slow_ns) sda_pull = ~b;
      #100 scl = 1'h1;
      #50 scl = 1'h0;
   endtask

   // Released before the rise so the slave may pull it low
   task automatic get_bit(output logic b);
      #(50 + slow_ns) sda_pull = 1'h0;
      #100 scl = 1'h1;
      #25 b = sda_line;
      #25 scl = 1'h0;
   endtask

   task automatic start_cond();
      if (scl == 1'h0)
      begin
         #(50 + slow_ns) sda_pull = 1'h0;
         #100 scl = 1'h1;
      end
      #100 sda_pull = 1'h1; // Data falls while clock high
      #100 scl = 1'h0;
   endtask

   task automatic stop_cond();
      #(50 + slow_ns) sda_pull = 1'h1;
      #100 scl = 1'h1;
      #100 sda_pull = 1'h0; // Data rises while clock high
      #100;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // MSB first, eight bits then the acknowledge slot
   task automatic send_byte(input logic [7:0] d, output logic acked);
      logic b;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(b);
      acked = ~b;
   endtask

   task automatic recv_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(last); // Master acknowledges all but the last byte
   endtask

endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the charger two-wire slave.
`timescale 1ns/10ps
module tb
   import chgi2c_pkg::*;
;
   // Identification byte handed to the design; the value is arbitrary
   localparam logic [7:0] ID_EXP = 8'h5A;

   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic scl, m_pull, sda_wire, sda_out, sda_oe;
   logic host_pin = 1'h0;
   logic st_hi = 1'h0;
   logic st_lo = 1'h0;
   logic step_up = 1'h0;
   logic [2:0] fault = 3'h0;
   logic timer_restart, stat_enable, fault_present, hs_mode;
   logic [7:0] cfg_control, cfg_voltage, cfg_current;
   int error_cnt = 0;
   int samples_checked = 0;
   int tr_cnt = 0;
   logic [7:0] unmapped [4] = '{8'h05, 8'h07, 8'h08, 8'h80};

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // Pull-up: the wire is high unless some party pulls it low
   assign sda_wire = ~(m_pull | (sda_oe & ~sda_out));

   chgi2c_master_model m (.scl(scl), .sda_pull(m_pull), .sda_line(sda_wire));

   chgi2c_slave #(.ID_VALUE(ID_EXP)) DUT (
      .clk(clk), .reset_n(reset_n), .scl_pin(scl), .sda_pin(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .host_detect_pin(host_pin),
      .charge_state_hi(st_hi), .charge_state_lo(st_lo),
      .step_up_active(step_up), .fault_code(fault),
      .timer_restart(timer_restart), .stat_enable(stat_enable),
      .fault_present(fault_present), .hs_mode(hs_mode),
      .cfg_control(cfg_control), .cfg_voltage(cfg_voltage),
      .cfg_current(cfg_current));

   always @(posedge clk)
      if (timer_restart === 1'h1)
         tr_cnt <= tr_cnt + 1;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic exp_fault(logic up, logic [2:0] f);
      return (f != FLT_NORMAL) && !(up && f == FLT_UP_UNUSED);
   endfunction

   task automatic open_dev(input logic rd);
      logic a;
      m.start_cond();
      m.send_byte({DEV_ADDR, rd}, a);
      check("address ack", {7'h00, a}, 8'h01);
   endtask

   task automatic wr_pair(input logic [7:0] ptr, input logic [7:0] d);
      logic a, b;
      m.send_byte(ptr, a);
      m.send_byte(d, b);
      check("write acks", {6'h00, a, b}, 8'h03);
   endtask

   // Pointer write, repeated start, one byte read with a closing nack
   task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      open_dev(1'h0);
      m.send_byte(ptr, a);
      check("pointer ack", {7'h00, a}, 8'h01);
      open_dev(1'h1);
      m.recv_byte(1'h1, d);
      m.stop_cond();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #2_000_000;
      error_cnt++;
      $display("Error watchdog expected finish seen timeout");
      print_verdict();
   end

   initial
   begin
      logic [7:0] d, v, c, w;
      logic a, b;
      int n0;
      void'($urandom(32'hd653ca83));
      repeat (6) @(negedge clk);
      reset_n = 1'h1;
      repeat (4) @(negedge clk);
      check("reset control", cfg_control, CONTROL_RESET);
      check("reset voltage", cfg_voltage, VOLTAGE_RESET);
      check("reset current", cfg_current, CURRENT_RESET);
      check("reset flags", {5'h00, stat_enable, hs_mode, sda_oe}, 8'h04);
      // Two pairs in one transaction; garbage aimed at read-only bits
      v = {~VOLTAGE_RESET[7], 7'($urandom)};
      n0 = tr_cnt;
      open_dev(1'h0);
      wr_pair(8'h00, 8'h3F);
      m.send_byte(8'h02, a);
      m.send_byte(v, a);
      check("voltage before commit", cfg_voltage, VOLTAGE_RESET);
      #200;
      check("voltage after commit", cfg_voltage, v);
      m.stop_cond();
      check("indicator enable", {7'h00, stat_enable}, 8'h00);
      check("restart pulses", 8'(tr_cnt - n0), 8'h00);
      open_dev(1'h0);
      wr_pair(8'h00, 8'hC0);
      m.stop_cond();
      check("restart pulses", 8'(tr_cnt - n0), 8'h01);
      check("indicator enable", {7'h00, stat_enable}, 8'h01);
      // Live status for every fault code in both operations
      for (int k = 0; k < 16; k++)
      begin
         @(negedge clk);
         m.slow_ns = int'($urandom_range(300));
         host_pin = 1'($urandom);
         {st_hi, st_lo} = 2'($urandom);
         step_up = k[3];
         fault = k[2:0];
         reg_read(8'h00, d);
         check("status", d, {host_pin, 1'h1, st_hi, st_lo, step_up, fault});
         check("fault flag", {7'h00, fault_present}, {7'h00, exp_fault(step_up, fault)});
      end
      m.slow_ns = 0;
      foreach (unmapped[i])
      begin
         reg_read(unmapped[i], d);
         check("unmapped read", d, UNMAPPED_BYTE);
      end
      reg_read(8'h02, d);
      check("voltage read", d, v);
      // Master ack asks for the same register once more
      open_dev(1'h0);
      m.send_byte(8'h02, a);
      open_dev(1'h1);
      m.recv_byte(1'h0, d);
      m.recv_byte(1'h1, w);
      m.stop_cond();
      check("burst first", d, v);
      check("burst second", w, v);
      open_dev(1'h0);
      wr_pair(8'h03, ~ID_EXP);
      w = 8'($urandom);
      wr_pair(8'h04, w);
      m.stop_cond();
      check("current written", cfg_current, w);
      reg_read(8'h03, d);
      check("id read", d, ID_EXP);
      reg_read(8'h04, d);
      check("current read", d, w);
      // Foreign address is ignored until the stop
      m.start_cond();
      m.send_byte({7'h55, 1'h0}, a);
      check("foreign ack", {7'h00, a}, 8'h00);
      m.send_byte(8'h01, a);
      m.send_byte(8'hFF, b);
      check("foreign bytes", {6'h00, a, b}, 8'h00);
      m.stop_cond();
      check("control kept", cfg_control, CONTROL_RESET);
      // Abandoned mid-byte, then the stop must recover the slave
      open_dev(1'h0);
      repeat (4) m.put_bit(1'h0);
      m.stop_cond();
      c = 8'($urandom);
      m.start_cond();
      m.send_byte({5'h01, 3'($urandom)}, a); // Sent at the same rate as the bytes that follow
      check("master code ack", {7'h00, a}, 8'h00);
      check("fast mode on", {7'h00, hs_mode}, 8'h01);
      open_dev(1'h0); // Repeated start keeps fast mode
      wr_pair(8'h01, c);
      check("fast mode kept", {7'h00, hs_mode}, 8'h01);
      m.stop_cond();
      check("control written", cfg_control, c);
      check("fast mode off", {7'h00, hs_mode}, 8'h00);
      print_verdict();
   end

endmodule
